// file: scp_clk_ctrl.sv
// System clock source selection and PLL control register.
// Assumes register strobes are synchronous to ref_clk; the PLL lock level
// comes from the analog PLL and is synchronised here.
`timescale 1ns/10ps
module scp_clk_ctrl
  import scp_pkg::*;
#(
  parameter int unsigned GAP_CYC = scp_pkg::SW_GAP_CYC
)
(
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         reg_wr_en,
  input  wire logic [scp_pkg::CTL_W-1:0]    reg_wr_data,
  output logic      [scp_pkg::CTL_W-1:0]    reg_rd_data,
  input  wire logic                         pll_lock_raw,
  output logic                              in_diff_sel,
  output logic                              in_xtal_sel,
  output logic                              in_cmos_sel,
  output logic                              pll_enable,
  output logic                              pll_pd,
  output logic                              pll_rst_n,
  output logic                              pll_lo_range,
  output logic                              ref_div2,
  output logic                              vco_sel,
  output logic                              out_div2,
  output logic                              fb_div2,
  output logic      [scp_pkg::FB_N_W-1:0]   fb_div_n,
  output logic      [scp_pkg::MULT_Q_W-1:0] mult_q,
  output logic                              sel_ref_clk,
  output logic                              sel_pll_clk
);
  import scp_pkg::*;

  // Gap counter is four bits wide, so a longer gap cannot be served
  if (GAP_CYC < 1 || GAP_CYC > 15) begin : g_bad_gap
    $error("GAP_CYC must lie in 1..15");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register; bit 0 is never stored
  logic [CTL_W-1:0] ctl;
  wire  logic [CTL_W-1:0] next_ctl = reg_wr_en ? (reg_wr_data & CTL_WR_MASK) : ctl;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl <= CTL_RESET;
    end else begin
      ctl <= next_ctl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lock synchroniser; only the second stage is looked at
  logic lock_meta;
  logic lock_sync;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= pll_lock_raw;
      lock_sync <= lock_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode; xtal ignores the top bit, CMOS only when top set and xtal clear
  wire logic [2:0] mode     = ctl[MODE_MSB:MODE_LSB];
  wire logic dec_xtal       = mode[1];
  wire logic dec_cmos       = mode[2] & ~mode[1];
  wire logic dec_diff       = ~mode[2] & ~mode[1];
  wire logic dec_pll_en     = ~ctl[BIT_PLL_PD];
  wire logic [MULT_Q_W-1:0] calc_mult_q;

  scp_mult_calc u_mult (
    .fb_n     (ctl[FB_N_MSB:FB_N_LSB]),
    .fb_div2  (ctl[BIT_FB_DIV2]),
    .out_div2 (ctl[BIT_OUT_DIV2]),
    .in_div2  (ctl[BIT_IN_DIV2]),
    .mult_q   (calc_mult_q)
  );

  // Static controls to the analog side, registered so every output is a flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_diff_sel  <= 1'b1;
      in_xtal_sel  <= 1'b0;
      in_cmos_sel  <= 1'b0;
      pll_enable   <= 1'b0;
      pll_pd       <= 1'b1;
      pll_rst_n    <= 1'b0;
      pll_lo_range <= 1'b0;
      ref_div2     <= 1'b0;
      vco_sel      <= 1'b0;
      out_div2     <= 1'b0;
      fb_div2      <= 1'b0;
      fb_div_n     <= 5'h00;
      mult_q       <= 9'h000;
    end else begin
      in_diff_sel  <= dec_diff;
      in_xtal_sel  <= dec_xtal;
      in_cmos_sel  <= dec_cmos;
      pll_enable   <= dec_pll_en;
      pll_pd       <= ctl[BIT_PLL_PD];
      pll_rst_n    <= ctl[BIT_RST_REL];
      pll_lo_range <= ctl[BIT_LO_RANGE];
      ref_div2     <= ctl[BIT_IN_DIV2];
      vco_sel      <= ctl[BIT_VCO_SEL];
      out_div2     <= ctl[BIT_OUT_DIV2];
      fb_div2      <= ctl[BIT_FB_DIV2];
      fb_div_n     <= ctl[FB_N_MSB:FB_N_LSB];
      mult_q       <= calc_mult_q;
    end
  end

  // Read path shows stored bits with live lock in bit 0
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rd_data <= CTL_RESET;
    end else begin
      reg_rd_data <= {ctl[CTL_W-1:1], lock_sync};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock switch: both selects low for a gap so no runt pulse reaches
  // the system clock; costs a few cycles of latency on each change
  wire logic want_pll = dec_pll_en & ctl[BIT_RST_REL] & lock_sync;

  scp_sw_e sw_state;
  scp_sw_e next_sw_state;
  logic [GAP_CNT_W-1:0] gap_cnt;
  wire  logic gap_done = (gap_cnt == GAP_CNT_W'(GAP_CYC - 1));

  always_comb begin
    next_sw_state = sw_state;
    case (sw_state)
      SCP_SW_REF: begin
        if (want_pll) begin
          next_sw_state = SCP_SW_TO_PLL;
        end
      end
      SCP_SW_TO_PLL: begin
        if (!want_pll) begin
          next_sw_state = SCP_SW_TO_REF;
        end else if (gap_done) begin
          next_sw_state = SCP_SW_PLL;
        end
      end
      SCP_SW_PLL: begin
        if (!want_pll) begin
          next_sw_state = SCP_SW_TO_REF;
        end
      end
      SCP_SW_TO_REF: begin
        if (gap_done) begin
          next_sw_state = SCP_SW_REF;
        end
      end
      default: next_sw_state = SCP_SW_REF;
    endcase
  end

  wire logic in_gap = (sw_state == SCP_SW_TO_PLL) || (sw_state == SCP_SW_TO_REF);
  wire logic [GAP_CNT_W-1:0] next_gap_cnt =
    (in_gap && (next_sw_state == sw_state)) ? gap_cnt + 1'b1 : '0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sw_state <= SCP_SW_REF;
      gap_cnt  <= '0;
    end else begin
      sw_state <= next_sw_state;
      gap_cnt  <= next_gap_cnt;
    end
  end

  // Selects follow the next state so they change with the state itself
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_ref_clk <= 1'b1;
      sel_pll_clk <= 1'b0;
    end else begin
      sel_ref_clk <= (next_sw_state == SCP_SW_REF);
      sel_pll_clk <= (next_sw_state == SCP_SW_PLL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_mode_onehot: assert property (
    $onehot({in_diff_sel, in_xtal_sel, in_cmos_sel}))
    else $error("input type select not one-hot");

  chk_cmos_select: assert property (
    in_cmos_sel == $past(ctl[BIT_CMOS] & ~ctl[BIT_XTAL]))
    else $error("CMOS select does not follow mode field");

  chk_xtal_select: assert property (
    in_xtal_sel == $past(ctl[BIT_XTAL]))
    else $error("crystal select does not follow mode field");

  chk_pll_enable: assert property (
    pll_enable == !$past(ctl[BIT_PLL_PD]))
    else $error("PLL enable does not follow mode field");

  chk_ref_divider: assert property (
    ref_div2 == $past(ctl[BIT_IN_DIV2]))
    else $error("input divider does not follow control register");

  chk_vco_select: assert property (
    vco_sel == $past(ctl[BIT_VCO_SEL]))
    else $error("oscillator select does not follow control register");

  chk_fb_divider: assert property (
    fb_div_n == $past(ctl[FB_N_MSB:FB_N_LSB]) && fb_div2 == $past(ctl[BIT_FB_DIV2]))
    else $error("feedback divider does not follow control register");

  chk_pll_power: assert property (
    reg_wr_en ##1 1'b1 |=> pll_pd == $past(reg_wr_data[BIT_PLL_PD], 2))
    else $error("PLL power-down does not follow write");

  chk_pll_reset: assert property (
    reg_wr_en ##1 1'b1 |=> pll_rst_n == $past(reg_wr_data[BIT_RST_REL], 2))
    else $error("PLL reset-release does not follow write");

  chk_lock_readback: assert property (
    $rose(pll_lock_raw) ##1 pll_lock_raw |=> ##1 reg_rd_data[BIT_LOCK])
    else $error("lock status not visible within three cycles");

  chk_lock_write_ignored: assert property (
    reg_wr_en && reg_wr_data[BIT_LOCK] && !lock_sync ##1 !lock_sync |=>
      !reg_rd_data[BIT_LOCK])
    else $error("write to lock bit took effect");

  chk_no_overlap: assert property (
    !(sel_ref_clk && sel_pll_clk))
    else $error("both clock selects active");

  // The other select was already low GAP_CYC cycles before either one rises
  chk_break_gap: assert property (
    $rose(sel_pll_clk) |-> $past(!sel_ref_clk, GAP_CYC))
    else $error("PLL selected before the full gap after reference dropped");

  chk_ref_gap: assert property (
    $rose(sel_ref_clk) |-> $past(!sel_pll_clk, GAP_CYC))
    else $error("reference selected before the full gap after PLL dropped");

  // Runs of want_pll high and low, saturating; a lock that arrives just as a
  // gap back to the reference opens needs two gaps and a cycle to reach the PLL
  localparam int unsigned HI_SETTLE = 2 * GAP_CYC + 1;
  localparam int unsigned LO_SETTLE = GAP_CYC + 1;
  logic [5:0] want_hi_run;
  logic [5:0] want_lo_run;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      want_hi_run <= 6'h00;
      want_lo_run <= 6'h00;
    end else begin
      want_hi_run <= want_pll ? want_hi_run + 6'(want_hi_run != 6'h3f) : 6'h00;
      want_lo_run <= want_pll ? 6'h00 : want_lo_run + 6'(want_lo_run != 6'h3f);
    end
  end

  chk_switch_to_pll: assert property (
    want_hi_run >= 6'(HI_SETTLE) |-> sel_pll_clk)
    else $error("PLL not selected after lock");

  chk_back_to_ref: assert property (
    want_lo_run >= 6'(LO_SETTLE) |-> sel_ref_clk)
    else $error("reference not reselected after lock loss");

  chk_mult_zero_n: assert property (
    ctl[FB_N_MSB:FB_N_LSB] == 5'h00 && ctl[BIT_FB_DIV2] && !ctl[BIT_OUT_DIV2] &&
      !ctl[BIT_IN_DIV2] |=> mult_q == 9'h100)
    else $error("N of zero with doubling is not 64");

  cov_lock_to_pll:  cover property ($rose(sel_pll_clk));
  cov_lock_lost:    cover property ($fell(sel_pll_clk) ##[1:8] sel_ref_clk);
  cov_cmos_pll:     cover property (in_cmos_sel && pll_enable && sel_pll_clk);

endmodule

// file: scp_clk_ctrl_bench.sv
// Self-checking bench for the system clock source and PLL control block.
// Assumes scp_pkg and scp_clk_ctrl are compiled first; the bench plays the
// register writer and the analog PLL lock line itself.
`timescale 1ns/10ps
module scp_clk_ctrl_bench;
  import scp_pkg::*;

  // Gap above the default so the parameter really reaches the switch logic
  localparam int unsigned GAP = 3;

  logic             ref_clk      = 1'b0;
  logic             rst          = 1'b1;
  logic             reg_wr_en    = 1'b0;
  logic [CTL_W-1:0] reg_wr_data  = 16'h0000;
  logic             pll_lock_raw = 1'b0;
  logic [CTL_W-1:0] reg_rd_data;
  logic [FB_N_W-1:0] fb_div_n;
  logic [MULT_Q_W-1:0] mult_q;
  logic             in_diff_sel, in_xtal_sel, in_cmos_sel, pll_enable, pll_pd;
  logic             pll_rst_n, pll_lo_range, ref_div2, vco_sel, out_div2;
  logic             fb_div2, sel_ref_clk, sel_pll_clk;
  int               error_cnt   = 0;
  int               check_count = 0;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  scp_clk_ctrl #(.GAP_CYC(GAP)) DUT (
    .ref_clk(ref_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .pll_lock_raw(pll_lock_raw), .in_diff_sel(in_diff_sel),
    .in_xtal_sel(in_xtal_sel), .in_cmos_sel(in_cmos_sel), .pll_enable(pll_enable),
    .pll_pd(pll_pd), .pll_rst_n(pll_rst_n), .pll_lo_range(pll_lo_range),
    .ref_div2(ref_div2), .vco_sel(vco_sel), .out_div2(out_div2), .fb_div2(fb_div2),
    .fb_div_n(fb_div_n), .mult_q(mult_q), .sel_ref_clk(sel_ref_clk),
    .sel_pll_clk(sel_pll_clk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One write; returns one edge after the take, when decoded outputs have settled
  task automatic wr(input logic [15:0] d);
    reg_wr_en = 1'b1;
    reg_wr_data = d;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // Edges until a select reaches a level; both selects high is never allowed
  task automatic edges_until(input logic pll_side, input logic lvl, output int n);
    n = 0;
    while (((pll_side ? sel_pll_clk : sel_ref_clk) !== lvl) && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
      check({15'h0, sel_ref_clk & sel_pll_clk}, 16'h0);
    end
    if (n >= 40) begin
      error_cnt++;
      finish_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_modes();
    logic [2:0] m;
    logic [4:0] e;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      wr({8'h00, m, 5'h02});
      e = {~m[1] & ~m[2], m[1], ~m[1] & m[2], ~m[0], m[0]};
      check({11'h0, in_diff_sel, in_xtal_sel, in_cmos_sel, pll_enable, pll_pd}, {11'h0, e});
    end
    $display("modes done");
  endtask

  // Two complementary patterns catch stuck and swapped field bits
  task automatic t_fields();
    wr(16'haa1f);
    check(reg_rd_data, 16'haa1e);
    check({5'h0, out_div2, fb_div2, fb_div_n, pll_lo_range, ref_div2, vco_sel, pll_rst_n},
          {5'h0, 1'b1, 1'b0, 5'h15, 4'hf});
    wr(16'h55e0);
    check(reg_rd_data, 16'h55e0);
    check({5'h0, out_div2, fb_div2, fb_div_n, pll_lo_range, ref_div2, vco_sel, pll_rst_n},
          {5'h0, 1'b0, 1'b1, 5'h0a, 4'h0});
    $display("fields done");
  endtask

  // Every N with every divider combination, in quarter units
  task automatic t_mult();
    logic [15:0] q;
    for (int k = 0; k < 256; k++) begin
      wr({k[2], k[1], k[7:3], 5'h00, k[0], 3'h0});
      q = (k[7:3] == 5'h00) ? 16'h0080 : {9'h0, k[7:3], 2'h0};
      if (k[1]) q = q << 1;
      if (k[2]) q = q >> 1;
      if (k[0]) q = q >> 1;
      check({7'h0, mult_q}, q);
    end
    $display("multiplier done");
  endtask

  // Lock arrives, is lost and returns; lock passes two sync flops first
  task automatic t_lock();
    int n;
    // Modest feedback ratio keeps the system clock within its limit
    wr(16'h0802);
    check({14'h0, sel_ref_clk, sel_pll_clk}, 16'h2);
    pll_lock_raw = 1'b1;
    edges_until(1'b0, 1'b0, n);
    check(16'(n), 16'h3);
    check({15'h0, reg_rd_data[0]}, 16'h1);
    edges_until(1'b1, 1'b1, n);
    check(16'(n), 16'(GAP));
    pll_lock_raw = 1'b0;
    edges_until(1'b1, 1'b0, n);
    check(16'(n), 16'h3);
    edges_until(1'b0, 1'b1, n);
    check(16'(n), 16'(GAP));
    pll_lock_raw = 1'b1;
    edges_until(1'b1, 1'b1, n);
    check(16'(n), 16'(3 + GAP));
    $display("lock done");
  endtask

  // Lock alone must not switch while the PLL is powered down or while PLL logic is held
  task automatic t_hold();
    int n;
    wr(16'h0022);
    repeat (12) @(posedge ref_clk);
    #1;
    check({14'h0, sel_ref_clk, sel_pll_clk}, 16'h2);
    check({15'h0, reg_rd_data[0]}, 16'h1);
    wr(16'h0000);
    repeat (12) @(posedge ref_clk);
    #1;
    check({14'h0, sel_ref_clk, sel_pll_clk}, 16'h2);
    wr(16'h0802);
    edges_until(1'b1, 1'b1, n);
    check(16'(n), 16'(GAP));
    $display("hold done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    check(reg_rd_data, 16'h0020);
    check({9'h0, in_diff_sel, in_xtal_sel, in_cmos_sel, pll_pd, pll_rst_n,
           sel_ref_clk, sel_pll_clk}, 16'h004a);
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    check({7'h0, mult_q}, 16'h0080);
    $display("reset done");
    t_modes();
    t_fields();
    t_mult();
    t_lock();
    t_hold();
    finish_test();
  end
endmodule

// file: scp_mult_calc.sv
// Effective PLL multiplication factor, in quarter units, from the divider bits.
// Assumes purely combinational use; the caller registers the result.
`timescale 1ns/10ps
module scp_mult_calc
  import scp_pkg::*;
(
  input  wire logic [scp_pkg::FB_N_W-1:0]   fb_n,
  input  wire logic                         fb_div2,
  input  wire logic                         out_div2,
  input  wire logic                         in_div2,
  output logic      [scp_pkg::MULT_Q_W-1:0] mult_q
);

  // Field value zero behaves as 32
  function automatic logic [5:0] eff_n(input logic [4:0] n);
    eff_n = (n == 5'h00) ? FB_N_ZERO_AS : {1'b0, n};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Doubling raises the shift, each halving lowers it; never negative
  wire logic [2:0] up_shift   = {1'b0, MULT_Q_SHIFT} + {2'b00, fb_div2};
  wire logic [2:0] down_shift = {2'b00, out_div2} + {2'b00, in_div2};
  wire logic [2:0] net_shift  = up_shift - down_shift;
  wire logic [8:0] base_n     = {3'b000, eff_n(fb_n)};

  assign mult_q = base_n << net_shift;

endmodule

// file: scp_pkg.sv
// Constants for the system clock source and PLL control block.
// Assumes a single 200 MHz register clock; all users import scp_pkg::*.
package scp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register layout
  localparam int unsigned CTL_W          = 16;
  localparam int unsigned BIT_OUT_DIV2   = 15;
  localparam int unsigned BIT_FB_DIV2    = 14;
  localparam int unsigned FB_N_MSB       = 13;
  localparam int unsigned FB_N_LSB       = 9;
  localparam int unsigned FB_N_W         = 5;
  localparam int unsigned MODE_MSB       = 7;
  localparam int unsigned MODE_LSB       = 5;
  localparam int unsigned BIT_CMOS       = 7;
  localparam int unsigned BIT_XTAL       = 6;
  localparam int unsigned BIT_PLL_PD     = 5;
  localparam int unsigned BIT_LO_RANGE   = 4;
  localparam int unsigned BIT_IN_DIV2    = 3;
  localparam int unsigned BIT_VCO_SEL    = 2;
  localparam int unsigned BIT_RST_REL    = 1;
  localparam int unsigned BIT_LOCK       = 0;

  // Reset: differential input, PLL powered down and held in reset
  localparam logic [15:0] CTL_RESET      = 16'h0020;
  // Lock bit is never stored
  localparam logic [15:0] CTL_WR_MASK    = 16'hfffe;

  ////////////////////////////////////////////////////////////////////////////////
  // Multiplier arithmetic, expressed in quarter units
  localparam int unsigned MULT_Q_W       = 9;
  localparam logic [5:0]  FB_N_ZERO_AS   = 6'h20;
  localparam logic [1:0]  MULT_Q_SHIFT   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned SW_GAP_NS      = 10;
  localparam int unsigned SW_GAP_CYC     =
    (SW_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GAP_CNT_W      = 4;

  // Clock switch states
  typedef enum logic [1:0] {
    SCP_SW_REF    = 2'b00,
    SCP_SW_TO_PLL = 2'b01,
    SCP_SW_PLL    = 2'b10,
    SCP_SW_TO_REF = 2'b11
  } scp_sw_e;

endpackage
